// ### logic/esc_rail.sv
// One rail's voltage feedback path with its AHB-Lite register slave.
// Assumes sense_pos_in/sense_neg_in are synchronous sampled words in 1 mV units,
// a rail-mode input from sequencing logic and a measured-current input.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module esc_rail
  import esc_pkg::*;
#(
  parameter int SLEW_CYC = ESC_SLEW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [ESC_SENSE_W-1:0] sense_pos_in,
  input wire logic [ESC_SENSE_W-1:0] sense_neg_in,
  input wire logic ramp_or_track,
  input wire logic [15:0] iout_meas,
  output logic [ESC_DUTY_W-1:0] duty_out,
  output logic duty_valid
);
  // Bus slave
  esc_aphase_s ap_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] period_reg;
  logic [15:0] trig_reg;
  logic [15:0] light_reg;
  logic [ESC_REF_W-1:0] ref_reg;
  logic [31:0] rdata_reg;
  logic rd_pend_reg;
  wire ap_valid = hsel & hready & htrans[1];
  wire wr_ctrl = ap_reg.sel & ap_reg.wr & (ap_reg.addr == ESC_A_CTRL);
  wire wr_period = ap_reg.sel & ap_reg.wr & (ap_reg.addr == ESC_A_PERIOD);
  wire wr_trig = ap_reg.sel & ap_reg.wr & (ap_reg.addr == ESC_A_TRIG);
  wire wr_ref = ap_reg.sel & ap_reg.wr & (ap_reg.addr == ESC_A_REF);
  wire wr_light = ap_reg.sel & ap_reg.wr & (ap_reg.addr == ESC_A_LIGHT);
  // Bank space ends at 0x100, one past the byte address, so compare on nine bits
  wire wr_bank = ap_reg.sel & ap_reg.wr & (ap_reg.addr >= ESC_A_BANK) &
    ({1'b0, ap_reg.addr} < 9'(ESC_A_BANK + 4 * ESC_BANK_WORDS * ESC_BANKS));
  wire [5:0] bank_waddr = 6'((ap_reg.addr - ESC_A_BANK) >> 2);

  // Datapath state, private to this rail so rails never share samples
  esc_state_e st_reg;
  logic [15:0] pcnt_reg;
  logic [1:0] bank_reg;
  logic [3:0] widx_reg;
  logic [31:0] cw [ESC_BANK_WORDS];
  logic signed [ESC_ERR_W-1:0] err_reg;
  logic signed [ESC_ACC_W-1:0] x1_reg, x2_reg, y1_reg, y2_reg, u1_reg, z1_reg;
  logic [ESC_DUTY_W-1:0] duty_reg;
  logic duty_v_reg;
  logic sat_reg;
  logic [15:0] slew_cnt_reg;
  logic [31:0] mem_rdata;

  // Bank choice from operating mode
  wire light = iout_meas < light_reg;
  wire [1:0] mode_sel = ramp_or_track ? ESC_MODE_RAMP :
                        (light ? ESC_MODE_LIGHT : ESC_MODE_REG);
  wire sample_hit = pcnt_reg == trig_reg;
  wire enable = ctrl_reg[0];

  // Conversion of the sampled error
  wire signed [ESC_SENSE_W+1:0] sense_diff =
    $signed({2'b00, sense_pos_in}) - $signed({2'b00, sense_neg_in});
  wire signed [ESC_SENSE_W+1:0] err_mv =
    $signed({4'h0, ref_reg}) - sense_diff;
  wire [1:0] gcode = cw[ESC_W_GAIN][1:0];
  // Step of 8,4,2,1 mV for codes 0..3
  wire signed [ESC_SENSE_W+1:0] err_q = err_mv >>> (2'd3 - gcode);
  wire signed [ESC_ERR_W-1:0] err_code =
    (err_q < ESC_SENSE_W'(0) + $signed(ESC_CLAMP_LO)) ? ESC_CLAMP_LO :
    (err_q > $signed(ESC_CLAMP_HI)) ? ESC_CLAMP_HI :
    err_q[ESC_ERR_W-1:0];

  logic signed [ESC_ERR_W+ESC_COEF_W-1:0] nl_out;
  esc_nonlin u_nonlin (
    .err(err_reg),
    .limits(cw[ESC_W_LIM]),
    .gains({cw[ESC_W_NLG0+4][15:0], cw[ESC_W_NLG0+3][15:0], cw[ESC_W_NLG0+2][15:0],
            cw[ESC_W_NLG0+1][15:0], cw[ESC_W_NLG0][15:0]}),
    .scaled(nl_out)
  );

  esc_coef_mem u_mem (
    .hclk(hclk),
    .we(wr_bank),
    .waddr(bank_waddr),
    .wdata(hwdata),
    .raddr(6'({bank_reg, widx_reg})),
    .rdata(mem_rdata)
  );

  function automatic logic signed [ESC_ACC_W-1:0] mulc(
    input logic signed [ESC_ACC_W-1:0] v, input logic [31:0] c);
    logic signed [ESC_ACC_W+ESC_COEF_W-1:0] p;
    p = v * $signed(c[ESC_COEF_W-1:0]);
    return ESC_ACC_W'(p >>> ESC_FRAC);
  endfunction

  // Second-order section, then first-order section for the third pole/zero
  wire signed [ESC_ACC_W-1:0] x0 = ESC_ACC_W'(nl_out);
  wire signed [ESC_ACC_W-1:0] y0 = mulc(x0, cw[ESC_W_B0]) + mulc(x1_reg, cw[ESC_W_B1]) +
    mulc(x2_reg, cw[ESC_W_B2]) + mulc(y1_reg, cw[ESC_W_A1]) + mulc(y2_reg, cw[ESC_W_A2]);
  wire signed [ESC_ACC_W-1:0] z0 = mulc(y0, cw[ESC_W_C0]) + mulc(u1_reg, cw[ESC_W_C1]) +
    mulc(z1_reg, cw[ESC_W_D1]);
  wire [ESC_DUTY_W-1:0] z_sat = z0 < 0 ? '0 :
    (z0 > ESC_ACC_W'(16'hFFFF)) ? 16'hFFFF : z0[ESC_DUTY_W-1:0];

  // Bus write side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_reg <= '0;
      ctrl_reg <= ESC_CTRL_RST;
      period_reg <= ESC_PERIOD_RST;
      trig_reg <= ESC_TRIG_RST;
      light_reg <= 16'h0000;
    end else begin
      ap_reg <= '{sel: ap_valid, wr: hwrite, addr: haddr[7:0]};
      if (wr_ctrl) ctrl_reg <= hwdata;
      if (wr_period) period_reg <= hwdata[15:0];
      if (wr_trig) trig_reg <= hwdata[15:0];
      if (wr_light) light_reg <= hwdata[15:0];
    end
  end

  // Read mux, data available one cycle after the address phase
  wire [31:0] rd_mux = (haddr[7:0] == ESC_A_CTRL) ? ctrl_reg :
    (haddr[7:0] == ESC_A_PERIOD) ? {16'h0000, period_reg} :
    (haddr[7:0] == ESC_A_TRIG) ? {16'h0000, trig_reg} :
    (haddr[7:0] == ESC_A_REF) ? {22'h00_0000, ref_reg} :
    (haddr[7:0] == ESC_A_STAT) ? {24'h00_0000, sat_reg, bank_reg, st_reg, 1'b0} :
    (haddr[7:0] == ESC_A_DUTY) ? {16'h0000, duty_reg} :
    (haddr[7:0] == ESC_A_LIGHT) ? {16'h0000, light_reg} : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= ap_valid & ~hwrite;
      if (ap_valid & ~hwrite) rdata_reg <= rd_mux;
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Period counter and sample sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcnt_reg <= 16'h0000;
    end else if (pcnt_reg >= period_reg - 16'h0001) begin
      pcnt_reg <= 16'h0000;
    end else begin
      pcnt_reg <= pcnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ESC_IDLE;
      bank_reg <= 2'h1;
      widx_reg <= 4'h0;
      err_reg <= '0;
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
      u1_reg <= '0;
      z1_reg <= '0;
      duty_reg <= 16'h0000;
      duty_v_reg <= 1'b0;
    end else begin
      duty_v_reg <= 1'b0;
      unique case (st_reg)
        ESC_IDLE: begin
          if (enable && sample_hit) begin
            bank_reg <= mode_sel;
            widx_reg <= 4'h0;
            st_reg <= ESC_LOAD;
          end
        end
        ESC_LOAD: begin
          widx_reg <= widx_reg + 4'h1;
          if (widx_reg == 4'(ESC_BANK_WORDS - 1)) st_reg <= ESC_CALC;
        end
        ESC_CALC: begin
          err_reg <= err_code;
          st_reg <= ESC_OUT;
        end
        ESC_OUT: begin
          x2_reg <= x1_reg;
          x1_reg <= x0;
          y2_reg <= y1_reg;
          y1_reg <= y0;
          u1_reg <= y0;
          z1_reg <= z0;
          duty_reg <= z_sat;
          duty_v_reg <= 1'b1;
          st_reg <= ESC_IDLE;
        end
      endcase
    end
  end

  // Coefficient shadow fills one word per cycle behind the memory latency
  always_ff @(posedge hclk) begin
    if (st_reg == ESC_LOAD && widx_reg != 4'h0) cw[widx_reg - 4'h1] <= mem_rdata;
    if (st_reg == ESC_CALC) cw[ESC_BANK_WORDS - 1] <= mem_rdata;
  end

  // Reference: software set-point, slewed while converter is clamped
  wire clamped = (err_code == ESC_CLAMP_LO) || (err_code == ESC_CLAMP_HI);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_reg <= ESC_REF_RST;
      sat_reg <= 1'b0;
      slew_cnt_reg <= 16'h0000;
    end else begin
      if (st_reg == ESC_CALC) sat_reg <= clamped;
      if (wr_ref) begin
        ref_reg <= hwdata[ESC_REF_W-1:0];
        slew_cnt_reg <= 16'h0000;
      end else if (sat_reg && enable) begin
        if (slew_cnt_reg >= 16'(SLEW_CYC - 1)) begin
          slew_cnt_reg <= 16'h0000;
          // Positive error means reference above sense
          if (err_reg == ESC_CLAMP_HI && ref_reg != 10'h000) ref_reg <= ref_reg - 10'h001;
          else if (err_reg == ESC_CLAMP_LO && ref_reg != 10'h3FF) ref_reg <= ref_reg + 10'h001;
        end else begin
          slew_cnt_reg <= slew_cnt_reg + 16'h0001;
        end
      end else begin
        slew_cnt_reg <= 16'h0000;
      end
    end
  end

  assign duty_out = duty_reg;
  assign duty_valid = duty_v_reg;
endmodule

// ### logic/esc_pkg.sv
// Constants, register map and carriers for the error sampling compensator.
// Assumes an AHB-Lite master and a sense front end that delivers sampled words.
// Overview of operation
// - The sense input is captured at a programmable point within each switching period.
// - The error is the 10-bit reference set-point minus the sampled sense value.
// - The error is scaled by a programmable front gain before conversion.
// - Gain codes 0..3 give 1x,2x,4x,8x with a step of 8,4,2,1 mV.
// - Conversions beyond range clamp to -32 or +31 codes.
// - While clamped, the reference slews toward the sense at 0.156 V/ms.
// - Each coefficient bank carries its own front gain code.
// - Every rail has its own independent compensator instance.
// - A nonlinear gain feeds a second-order IIR which feeds a first-order IIR.
// - The first-order section supplies the third pole and third zero.
// - Bank 0 in ramps or tracking, bank 1 in regulation, bank 2 at light load.
// - Four thresholds split the error into five regions, each with its own gain.
// - Thresholds may be asymmetric, even all positive.
package esc_pkg;
  localparam int ESC_SENSE_W = 12;
  localparam int ESC_REF_W = 10;
  localparam int ESC_ERR_W = 6;
  localparam int ESC_DUTY_W = 16;
  localparam int ESC_COEF_W = 16;
  localparam int ESC_ACC_W = 40;
  localparam int ESC_FRAC = 12;
  localparam int ESC_BANKS = 3;
  localparam logic signed [5:0] ESC_CLAMP_LO = -6'sd32;
  localparam logic signed [5:0] ESC_CLAMP_HI = 6'sd31;
  // Slew: 0.156 V/ms, one reference step per sense LSB of 1 mV -> 156 steps/ms
  localparam int ESC_CLK_MHZ = 100;
  localparam int ESC_SLEW_UV_PER_MS = 156000;
  localparam int ESC_REF_LSB_UV = 1000;
  localparam int ESC_SLEW_CYC =
    (ESC_CLK_MHZ * 1000 * ESC_REF_LSB_UV) / ESC_SLEW_UV_PER_MS;
  localparam int ESC_PERIOD_W = 16;
  // Modes
  localparam logic [1:0] ESC_MODE_RAMP = 2'h0;
  localparam logic [1:0] ESC_MODE_REG = 2'h1;
  localparam logic [1:0] ESC_MODE_LIGHT = 2'h2;
  // Register byte offsets
  localparam logic [7:0] ESC_A_CTRL = 8'h00;
  localparam logic [7:0] ESC_A_PERIOD = 8'h04;
  localparam logic [7:0] ESC_A_TRIG = 8'h08;
  localparam logic [7:0] ESC_A_REF = 8'h0C;
  localparam logic [7:0] ESC_A_STAT = 8'h10;
  localparam logic [7:0] ESC_A_DUTY = 8'h14;
  localparam logic [7:0] ESC_A_LIGHT = 8'h18;
  localparam logic [7:0] ESC_A_BANK = 8'h40;
  localparam int ESC_BANK_WORDS = 16;
  localparam int ESC_MEM_DEPTH = 64;
  // Word map inside a bank
  localparam int ESC_W_GAIN = 0;
  localparam int ESC_W_LIM = 1;
  localparam int ESC_W_NLG0 = 2;
  localparam int ESC_W_B0 = 7;
  localparam int ESC_W_B1 = 8;
  localparam int ESC_W_B2 = 9;
  localparam int ESC_W_A1 = 10;
  localparam int ESC_W_A2 = 11;
  localparam int ESC_W_C0 = 12;
  localparam int ESC_W_C1 = 13;
  localparam int ESC_W_D1 = 14;
  localparam logic [31:0] ESC_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] ESC_PERIOD_RST = 16'h0064;
  localparam logic [15:0] ESC_TRIG_RST = 16'h0050;
  localparam logic [9:0] ESC_REF_RST = 10'h000;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
  } esc_aphase_s;

  typedef enum logic [3:0] {
    ESC_IDLE = 4'b0001,
    ESC_LOAD = 4'b0010,
    ESC_CALC = 4'b0100,
    ESC_OUT = 4'b1000
  } esc_state_e;
endpackage

// ### logic/esc_coef_mem.sv
// Coefficient memory for the three banks, registered read port.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module esc_coef_mem
  import esc_pkg::*;
#(
  parameter int DEPTH = ESC_MEM_DEPTH,
  parameter int AW = 6
) (
  input wire logic hclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### logic/esc_nonlin.sv
// Nonlinear gain: four limits, five regions, one gain each.
// Limits are signed codes in error units; gains are signed Q4.12.
`timescale 1ns/1ps
module esc_nonlin
  import esc_pkg::*;
(
  input wire logic signed [ESC_ERR_W-1:0] err,
  input wire logic [31:0] limits,
  input wire logic [5*ESC_COEF_W-1:0] gains,
  output logic signed [ESC_ERR_W+ESC_COEF_W-1:0] scaled
);
  logic [3:0] above;
  logic [2:0] region;
  logic signed [ESC_COEF_W-1:0] gain_sel;

  // Any ordering works, even all positive thresholds
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_cmp
      assign above[i] = err > $signed(limits[8*i +: ESC_ERR_W]);
    end
  endgenerate
  assign region = 3'(above[0]) + 3'(above[1]) + 3'(above[2]) + 3'(above[3]);
  assign gain_sel = $signed(gains[region*ESC_COEF_W +: ESC_COEF_W]);
  assign scaled = err * gain_sel;
endmodule

// ### tb/esc_sense_model.sv
// Sense divider model: the rail voltage seen across the differential inputs.
// Assumes the bench sets the wanted rail level in 1 mV steps.
`timescale 1ns/1ps
module esc_sense_model
  import esc_pkg::*;
(
  input wire logic [ESC_SENSE_W-1:0] target_mv,
  output logic [ESC_SENSE_W-1:0] sense_pos_in,
  output logic [ESC_SENSE_W-1:0] sense_neg_in
);
  // Common-mode offset so only the difference carries the rail level
  localparam logic [ESC_SENSE_W-1:0] NEG_BIAS = 12'h100;
  assign sense_neg_in = NEG_BIAS;
  assign sense_pos_in = NEG_BIAS + target_mv;
endmodule

// ### tb/esc_rail_chk.sv
// Port-level assertions for one rail's feedback path and register slave.
// Assumes a single clock domain and the rail's own ports only.
`timescale 1ns/1ps
module esc_rail_chk
  import esc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [ESC_DUTY_W-1:0] duty_out,
  input wire logic duty_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] gap_reg;
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  // Cycles since the last duty update, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_reg <= 8'h00;
    else if (duty_valid) gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  sequence hole_rd_s;
    rd_take && haddr[7:0] >= 8'h1C && haddr[7:0] <= 8'h3C;
  endsequence
  sequence stat_rd_s;
    rd_take && haddr[7:0] == ESC_A_STAT;
  endsequence
  pulse_single_a: assert property (duty_valid |=> !duty_valid)
    else $error("duty_valid longer than one cycle");
  duty_change_a: assert property ($changed(duty_out) |-> duty_valid)
    else $error("duty_out moved without duty_valid");
  sample_gap_a: assert property (duty_valid |-> gap_reg >= 8'd16)
    else $error("duty updates closer than one sample");
  ready_high_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave answered with an error");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("hrdata changed without a read");
  hole_zero_a: assert property (hole_rd_s |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  stat_state_a: assert property (stat_rd_s |=> $onehot(hrdata[4:1]))
    else $error("status state field not one-hot");
endmodule
bind esc_rail esc_rail_chk esc_rail_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .duty_out(duty_out), .duty_valid(duty_valid));

// ### tb/esc_rail_test.sv
// Self-checking bench for one rail: AHB-Lite master tasks and sense stimulus.
// Assumes the rail slave is alone on the bus, so hreadyout feeds hready.
`timescale 1ns/1ps
module esc_rail_test
  import esc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ramp_or_track, duty_valid;
  logic [31:0] haddr, hwdata, hrdata, r, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] iout_meas, duty_out, d0, d1, d2, da, db;
  logic [11:0] target_mv, sense_pos_in, sense_neg_in;
  int fails, cmp_count;
  esc_rail #(.SLEW_CYC(4)) esc_rail_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sense_pos_in(sense_pos_in), .sense_neg_in(sense_neg_in), .ramp_or_track(ramp_or_track),
    .iout_meas(iout_meas), .duty_out(duty_out), .duty_valid(duty_valid));
  esc_sense_model esc_sense_model_inst (.target_mv(target_mv), .sense_pos_in(sense_pos_in),
    .sense_neg_in(sense_neg_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One edge, then more while the slave holds hready low
  task automatic step();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    step();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    step();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
  // Stateless profile: nonlinear gains unity except the top one from g4, b0 and c0 at 1.0, all else 0
  task automatic set_bank(input int b, input logic [31:0] code, input logic [31:0] lim,
    input logic [31:0] g4);
    for (int w = 0; w < 16; w++) begin
      wr(8'(64 + b * 64 + w * 4), w == 0 ? code : w == 1 ? lim : w == 6 ? g4 :
        (w < 6 || w == 7 || w == 12) ? 32'h0000_1000 : 32'h0000_0000);
    end
  endtask
  // One conversion with the loop enabled, then disabled again
  task automatic meas(input logic [9:0] ref_v, input logic [11:0] mv, output logic [15:0] d);
    int n;
    wr(ESC_A_REF, {22'h0, ref_v});
    target_mv <= mv;
    wr(ESC_A_CTRL, 32'h0000_0001);
    n = 0;
    while (duty_valid !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      summarize();
    end
    d = duty_out;
    wr(ESC_A_CTRL, 32'h0000_0000);
  endtask
  initial begin
    fails = 0;
    cmp_count = 0;
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0000_0000;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0000_0000;
    ramp_or_track <= 1'b1;
    iout_meas <= 16'h01F4;
    target_mv <= 12'h000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ESC_A_CTRL, r); chk(r, 32'h0000_0000);
    rd(ESC_A_PERIOD, r); chk(r, 32'h0000_0064);
    rd(ESC_A_TRIG, r); chk(r, 32'h0000_0050);
    rd(ESC_A_REF, r); chk(r, 32'h0000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, r); chk(r, 32'h0000_0000);
    wr(ESC_A_TRIG, 32'h0000_0030);
    rd(ESC_A_TRIG, r); chk(r, 32'h0000_0030);
    // Host prefers 8x; other codes only to tell the banks apart
    set_bank(0, 32'h0000_0003, 32'h0804_FCF8, 32'h0000_1000);
    set_bank(1, 32'h0000_0000, 32'h0804_FCF8, 32'h0000_1000);
    set_bank(2, 32'h0000_0002, 32'h0804_FCF8, 32'h0000_1000);
    // Banks are write-only; their gain codes show in the duty values below
    rd(8'(64 + 128), r); chk(r, 32'h0000_0000);
    wr(ESC_A_LIGHT, 32'h0000_0064);
    meas(10'd600, 12'd584, d0);
    rd(ESC_A_STAT, r); chk({30'h0, r[6:5]}, 32'h0000_0000);
    ramp_or_track <= 1'b0;
    meas(10'd600, 12'd584, d1);
    rd(ESC_A_STAT, r); chk({30'h0, r[6:5]}, 32'h0000_0001);
    iout_meas <= 16'h0032;
    meas(10'd600, 12'd584, d2);
    rd(ESC_A_STAT, r); chk({30'h0, r[6:5]}, 32'h0000_0002);
    chk({31'h0, d0 > d2 && d2 > d1 && d1 > 16'h0000}, 32'h0000_0001);
    ramp_or_track <= 1'b1;
    meas(10'd600, 12'd569, da);
    meas(10'd600, 12'd500, db);
    chk({16'h0, db}, {16'h0, da});
    meas(10'd500, 12'd600, db);
    chk({16'h0, db}, 32'h0000_0000);
    // Slew rate: 40 cycles plus one read is 42 cycles, about 10 steps of 4
    wr(ESC_A_REF, 32'h0000_03E8);
    target_mv <= 12'h000;
    wr(ESC_A_CTRL, 32'h0000_0001);
    repeat (300) @(posedge hclk);
    rd(ESC_A_REF, r);
    repeat (40) @(posedge hclk);
    rd(ESC_A_REF, q);
    chk({31'h0, (r - q) >= 32'd9 && (r - q) <= 32'd12}, 32'h0000_0001);
    wr(ESC_A_CTRL, 32'h0000_0000);
    meas(10'd600, 12'd500, db);
    wr(ESC_A_CTRL, 32'h0000_0001);
    repeat (1500) @(posedge hclk);
    rd(ESC_A_REF, r);
    chk({31'h0, r >= 32'd500 && r <= 32'd530}, 32'h0000_0001);
    rd(ESC_A_STAT, q); chk({31'h0, q[7]}, 32'h0000_0000);
    repeat (300) @(posedge hclk);
    rd(ESC_A_REF, q); chk(q, r);
    wr(ESC_A_CTRL, 32'h0000_0000);
    // All limits positive, top region gain zero, then unity
    set_bank(0, 32'h0000_0003, 32'h0403_0201, 32'h0000_0000);
    meas(10'd510, 12'd500, da);
    chk({16'h0, da}, 32'h0000_0000);
    meas(10'd503, 12'd500, db);
    chk({31'h0, db > 16'h0000}, 32'h0000_0001);
    set_bank(0, 32'h0000_0003, 32'h0403_0201, 32'h0000_1000);
    meas(10'd510, 12'd500, da);
    chk({31'h0, da > 16'h0000}, 32'h0000_0001);
    summarize();
  end
endmodule
